// ===== verilog/ccu_map.svh
// Register indices, field positions, mode codes and reset values of the unit.
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH

// Register indices; the byte address is four times the index.
`define CCU_IDX_VAL_LO   8'h15
`define CCU_IDX_VAL_HI   8'h16
`define CCU_IDX_CTRL     8'h17
`define CCU_IDX_FLAG     8'h0c

// Field positions in the flag register.
`define CCU_FLG_OVF      0
`define CCU_FLG_EVT      2

// Mode field codes.
`define CCU_M_OFF        4'h0
`define CCU_M_CAP_FALL   4'h4
`define CCU_M_CAP_RISE   4'h5
`define CCU_M_CAP_R4     4'h6
`define CCU_M_CAP_R16    4'h7
`define CCU_M_CMP_HIGH   4'h8
`define CCU_M_CMP_LOW    4'h9
`define CCU_M_CMP_SOFT   4'ha
`define CCU_M_CMP_TRIG   4'hb

// Reset values and prescaler terminal counts.
`define CCU_CTRL_RST     6'h00
`define CCU_PS4_LAST     2'h3
`define CCU_PS16_LAST    4'hf

// Bus response codes.
`define CCU_RESP_OKAY    2'h0
`define CCU_RESP_SLVERR  2'h2

`endif

// ===== verilog/ccu_pkg.sv
// Types shared by the capture and compare unit.
package ccu_pkg;

  // Control register contents below the two bits that always read zero.
  typedef struct packed {
    logic [1:0] duty_low;
    logic [3:0] mode;
  } ccu_ctrl_t;

  // Flags that hardware sets and software clears.
  typedef struct packed {
    logic evt;
    logic ovf;
  } ccu_flags_t;

endpackage : ccu_pkg

// ===== verilog/ccu_top.sv
// Capture and compare unit against a 16-bit timer, with an AXI4-Lite slave.
// Function
// - A capture copies the whole 16-bit timer count into the value.
// - Capture on falling, rising, every 4th or every 16th rising edge.
// - Every capture sets the event flag at bit 2 of the flag register.
// - A new capture overwrites the held value without a copy.
// - The detector watches the pin level, so port writes can capture.
// - Prescaler clears on reset, when off, and outside capture modes.
// - Switching between capture prescales keeps the prescaler count.
// - In compare mode a timer match drives the pin high, low or not.
// - A compare match sets the event flag with the pin action.
// - Turning the unit off forces the compare output latch low.
// - The flag-only compare mode leaves the pin alone.
// - Special trigger clears the timer and starts enabled conversions.
// - The special trigger never sets the timer overflow flag.
// - Duty bits are ignored here; control bits 7 and 6 read zero.
// - Codes 0100 to 0111 capture, codes 1000 to 1011 compare.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "ccu_map.svh"

module ccu_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              nrst,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // AXI4-Lite read.
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Timer interface.
  input  wire logic [15:0]       timer_count,
  input  wire logic              timer_overflow,
  output logic                   timer_clear,
  // Converter interface.
  input  wire logic              adc_enable,
  output logic                   adc_start,
  // Event pin and flag.
  input  wire logic              pin_level,
  output logic                   cmp_out,
  output logic                   event_flag
);

  // True when a byte address equals four times a register index.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr == ADDR_W'({idx, 2'b00}));
  endfunction : reg_hit

  // Bus state.
  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_have_q;
  logic [31:0]       w_data_q;
  logic              w_strb0_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // Unit state.
  logic [15:0]          val_q;
  logic [15:0]          val_d;
  ccu_pkg::ccu_ctrl_t   ctrl_q;
  ccu_pkg::ccu_ctrl_t   ctrl_d;
  ccu_pkg::ccu_flags_t  flg_q;
  ccu_pkg::ccu_flags_t  flg_d;
  logic [3:0]           ps_q;
  logic                 pin_q;
  logic                 match_q;
  logic                 cmp_out_q;
  logic                 cmp_out_d;
  logic                 trig_q;
  logic                 adc_q;

  // Write decode; a write commits once address and data are both held.
  wire wr_go    = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_byte  = wr_go & w_strb0_q;
  wire wr_lo    = wr_byte & reg_hit(aw_addr_q, `CCU_IDX_VAL_LO);
  wire wr_hi    = wr_byte & reg_hit(aw_addr_q, `CCU_IDX_VAL_HI);
  wire wr_ctrl  = wr_byte & reg_hit(aw_addr_q, `CCU_IDX_CTRL);
  wire wr_flag  = wr_byte & reg_hit(aw_addr_q, `CCU_IDX_FLAG);
  wire wr_known = reg_hit(aw_addr_q, `CCU_IDX_VAL_LO) |
                  reg_hit(aw_addr_q, `CCU_IDX_VAL_HI) |
                  reg_hit(aw_addr_q, `CCU_IDX_CTRL) |
                  reg_hit(aw_addr_q, `CCU_IDX_FLAG);

  // Read decode and data selection.
  wire        rd_go  = s_arvalid & ~rvalid_q;
  wire        rd_lo  = reg_hit(s_araddr, `CCU_IDX_VAL_LO);
  wire        rd_hi  = reg_hit(s_araddr, `CCU_IDX_VAL_HI);
  wire        rd_ctl = reg_hit(s_araddr, `CCU_IDX_CTRL);
  wire        rd_flg = reg_hit(s_araddr, `CCU_IDX_FLAG);
  wire        rd_ok  = rd_lo | rd_hi | rd_ctl | rd_flg;
  wire [7:0]  ctl_rd = {2'b00, ctrl_q};
  wire [7:0]  flg_rd = {5'h00, flg_q.evt, 1'b0, flg_q.ovf};
  wire [7:0]  rd_sel = rd_lo  ? val_q[7:0]  :
                       rd_hi  ? val_q[15:8] :
                       rd_ctl ? ctl_rd      :
                       rd_flg ? flg_rd      : 8'h00;

  // Mode class decode.
  // mode class
  wire [3:0] mode   = ctrl_q.mode;
  wire       is_cap = (mode[3:2] == 2'b01);
  wire       is_cmp = (mode[3:2] == 2'b10);

  // Pin edge detection on the resolved pin level.
  // level watched
  wire rise = pin_level & ~pin_q;
  wire fall = ~pin_level & pin_q;

  // Capture qualification per mode.
  // edge select
  wire cap_hit = is_cap & (
    (mode == `CCU_M_CAP_FALL) ? fall :
    (mode == `CCU_M_CAP_RISE) ? rise :
    (mode == `CCU_M_CAP_R4)   ? rise & (ps_q[1:0] == `CCU_PS4_LAST) :
                                rise & (ps_q == `CCU_PS16_LAST));
  wire ps_step = rise & ((mode == `CCU_M_CAP_R4) | (mode == `CCU_M_CAP_R16));

  // Compare acts once when the equality begins.
  // value against timer
  wire match   = is_cmp & (timer_count == val_q);
  wire cmp_hit = match & ~match_q;
  wire trig    = cmp_hit & (mode == `CCU_M_CMP_TRIG);

  // Value register: a capture overrides a software byte write.
  always_comb
  begin
    val_d = val_q;
    if (wr_lo)
      val_d[7:0] = w_data_q[7:0];
    if (wr_hi)
      val_d[15:8] = w_data_q[7:0];
    if (cap_hit)
      val_d = timer_count;
  end

  // Control register keeps the duty bits; only the bus readback uses them.
  // duty ignored
  assign ctrl_d = wr_ctrl ? ccu_pkg::ccu_ctrl_t'(w_data_q[5:0]) : ctrl_q;

  // Flags: software writes the value, hardware sets win the same cycle.
  always_comb
  begin
    flg_d = flg_q;
    if (wr_flag)
    begin
      flg_d.evt = w_data_q[`CCU_FLG_EVT];
      flg_d.ovf = w_data_q[`CCU_FLG_OVF];
    end
    if (cap_hit | cmp_hit)
      flg_d.evt = 1'b1;
    if (timer_overflow)
      flg_d.ovf = 1'b1;
  end

  // Compare output latch.
  always_comb
  begin
    cmp_out_d = cmp_out_q;
    if (cmp_hit & (mode == `CCU_M_CMP_HIGH))
      cmp_out_d = 1'b1;
    if (cmp_hit & (mode == `CCU_M_CMP_LOW))
      cmp_out_d = 1'b0;
    if (mode == `CCU_M_OFF)
      cmp_out_d = 1'b0;
  end

  // Write address and data holding registers.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end
    else
    begin
      if (s_awvalid & s_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_awaddr;
      end
      else if (wr_go)
        aw_have_q <= 1'b0;
      if (s_wvalid & s_wready)
      begin
        w_have_q  <= 1'b1;
        w_data_q  <= s_wdata;
        w_strb0_q <= s_wstrb[0];
      end
      else if (wr_go)
        w_have_q <= 1'b0;
    end
  end

  // Write response.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CCU_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
    end
    else if (s_bready)
      bvalid_q <= 1'b0;
  end

  // Read response.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `CCU_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_sel};
      rresp_q  <= rd_ok ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
    end
    else if (s_rready)
      rvalid_q <= 1'b0;
  end

  // Unit registers.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      val_q     <= 16'h0000;
      ctrl_q    <= `CCU_CTRL_RST;
      flg_q     <= '0;
      cmp_out_q <= 1'b0;
      pin_q     <= 1'b0;
      match_q   <= 1'b0;
    end
    else
    begin
      val_q     <= val_d;
      ctrl_q    <= ctrl_d;
      flg_q     <= flg_d;
      cmp_out_q <= cmp_out_d;
      pin_q     <= pin_level;
      match_q   <= match;
    end
  end

  // Capture prescaler counter.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ps_q <= 4'h0;
    else if (!is_cap)
      ps_q <= 4'h0;
    else if (ps_step)
      ps_q <= ps_q + 4'h1;
  end

  // Special trigger pulses, one cycle each.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      trig_q <= 1'b0;
      adc_q  <= 1'b0;
    end
    else
    begin
      trig_q <= trig;
      adc_q  <= trig & adc_enable;
    end
  end

  // Outputs.
  assign s_awready  = ~aw_have_q;
  assign s_wready   = ~w_have_q;
  assign s_bvalid   = bvalid_q;
  assign s_bresp    = bresp_q;
  assign s_arready  = ~rvalid_q;
  assign s_rvalid   = rvalid_q;
  assign s_rdata    = rdata_q;
  assign s_rresp    = rresp_q;
  assign timer_clear = trig_q;
  assign adc_start  = adc_q;
  assign cmp_out    = cmp_out_q;
  assign event_flag = flg_q.evt;

endmodule : ccu_top

// ===== dv/ccu_checker.sv
// Port checks for the capture and compare unit.
`timescale 1ns/10ps
module ccu_checker (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        nrst,
  // Write channel handshakes and answer.
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [1:0]  s_bresp,
  // Read channel handshakes and answer.
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [31:0] s_rdata,
  // Pin, flag and trigger outputs.
  input wire logic        timer_clear,
  input wire logic        adc_start,
  input wire logic        cmp_out,
  input wire logic        event_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // The bus answers on time and holds each answer until it is taken.
  wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready |=> ##1 s_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read answer dropped");
  rdata_upper_a: assert property (s_rvalid |-> s_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Flag and trigger behaviour seen at the pins.
  flag_hold_a: assert property (event_flag |=> event_flag || $rose(s_bvalid))
    else $error("flag cleared by hardware");
  trig_pulse_a: assert property (timer_clear |=> !timer_clear)
    else $error("trigger longer than a cycle");
  adc_start_a: assert property (adc_start |-> timer_clear)
    else $error("conversion start without trigger");
  trig_flag_a: assert property (timer_clear |-> event_flag)
    else $error("trigger without flag");
  pin_flag_a: assert property ($changed(cmp_out) |-> event_flag || $past(s_bvalid))
    else $error("pin action without flag");
endmodule : ccu_checker

// ===== dv/ccu_pin_model.sv
// Outside source and load on the event pin, resolving its level.
`timescale 1ns/10ps
module ccu_pin_model (
  // Unit and stimulus side.
  input  wire logic cmp_out,
  input  wire logic ext_lvl,
  input  wire logic pin_dir_out,
  // Resolved pin.
  output logic      pin_level
);
  // pin direction
  // As an output the pin shows the compare latch, so the detector sees own drive.
  assign pin_level = pin_dir_out ? cmp_out : ext_lvl;
endmodule : ccu_pin_model

// ===== dv/tb.sv
// Self-checking bench for the capture and compare unit.
`timescale 1ns/10ps
`include "ccu_map.svh"
module tb;
  // Design ports and bench state.
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [15:0] timer_count, tset, v;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        mclk, nrst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, run;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, timer_overflow, timer_clear;
  logic        adc_enable, adc_start, pin_level, cmp_out, event_flag, ext_lvl, pin_dir_out;
  logic [33:0] exp_q[$];
  logic [1:0]  expb_q[$];
  logic [3:0]  modes[5] = '{4'h8, 4'ha, 4'h9, 4'hb, 4'hb};
  int          miscompares, num_checks, seed, n;
  ccu_top u_ccu_top (.*);
  ccu_pin_model u_ccu_pin_model (.*);
  // Clock at 125 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
    timer_count <= timer_clear ? 16'h0 : run ? timer_count + 16'h1 : tset;
  // Each read answer is compared with the oldest noted expectation.
  always @(posedge mclk)
    if (s_rvalid && s_rready)
    begin
      num_checks++;
      if ({s_rresp, s_rdata} !== exp_q.pop_front())
      begin
        miscompares++;
        $display("FAIL %0t read answer", $time);
      end
    end
  // Each write answer is compared with the oldest noted response code.
  always @(posedge mclk)
    if (s_bvalid && s_bready)
    begin
      num_checks++;
      if (s_bresp !== expb_q.pop_front())
      begin
        miscompares++;
        $display("FAIL %0t write answer", $time);
      end
    end
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r = 2'h0);
    expb_q.push_back(r);
    @(posedge mclk);
    s_awaddr <= {2'h0, idx, 2'h0};
    s_wdata <= {24'h0, d};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    #1;
    while (s_awvalid || s_wvalid || s_bready)
    begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) s_bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [1:0] r, input logic [7:0] d);
    exp_q.push_back({r, 24'h0, d});
    @(posedge mclk);
    s_araddr <= {2'h0, idx, 2'h0};
    {s_arvalid, s_rready} <= 2'h3;
    #1;
    while (s_arvalid || s_rready)
    begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) s_rready <= 1'b0;
    end
  endtask : rd
  task automatic ck(input logic got, input logic e);
    num_checks++;
    if (got !== e)
    begin
      miscompares++;
      $display("FAIL %0t pin or pulse", $time);
    end
  endtask : ck
  // One pin event: preset the timer, then a pulse away from the idle level.
  task automatic ev();
    @(posedge mclk) tset <= 16'($random(seed));
    repeat (2) @(posedge mclk) ext_lvl <= ~ext_lvl;
  endtask : ev
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Main sequence: registers, every capture mode, every compare mode.
  initial
  begin
    seed = 32'h4be51fa4;
    {nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, timer_overflow} = 7'h0;
    {adc_enable, ext_lvl, pin_dir_out, run, s_awaddr, s_araddr, s_wdata, tset} = '0;
    s_wstrb = 4'hf;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rd(`CCU_IDX_CTRL, 2'h0, 8'h00);
    rd(8'h00, 2'h2, 8'h00);
    wr(8'h00, 8'h55, 2'h2);
    wr(`CCU_IDX_CTRL, 8'hff);
    rd(`CCU_IDX_CTRL, 2'h0, 8'h3f);
    @(posedge mclk) timer_overflow <= 1'b1;
    @(posedge mclk) timer_overflow <= 1'b0;
    rd(`CCU_IDX_FLAG, 2'h0, 8'h01);
    $display("test registers done");
    for (int m = 4; m < 8; m++)
    begin
      n = m == 6 ? 4 : m == 7 ? 16 : 1;
      wr(`CCU_IDX_CTRL, 8'h00);
      ext_lvl <= m == 4;
      wr(`CCU_IDX_CTRL, 8'(m));
      wr(`CCU_IDX_FLAG, 8'h00);
      for (int i = 1; i <= 2 * n; i++)
      begin
        ev();
        if (i == n - 1) rd(`CCU_IDX_FLAG, 2'h0, 8'h00);
      end
      rd(`CCU_IDX_VAL_LO, 2'h0, tset[7:0]);
      rd(`CCU_IDX_VAL_HI, 2'h0, tset[15:8]);
      rd(`CCU_IDX_FLAG, 2'h0, 8'h04);
    end
    // Switching straight from the by-4 to the by-16 setting keeps the count.
    wr(`CCU_IDX_CTRL, 8'h00);
    wr(`CCU_IDX_CTRL, 8'h06);
    wr(`CCU_IDX_FLAG, 8'h00);
    for (int i = 1; i <= 16; i++)
    begin
      if (i == 3) wr(`CCU_IDX_CTRL, 8'h07);
      ev();
      if (i == 15) rd(`CCU_IDX_FLAG, 2'h0, 8'h00);
    end
    rd(`CCU_IDX_FLAG, 2'h0, 8'h04);
    rd(`CCU_IDX_VAL_LO, 2'h0, tset[7:0]);
    $display("test capture done");
    wr(`CCU_IDX_CTRL, 8'h00);
    pin_dir_out <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      {run, tset} <= 17'h0;
      adc_enable <= k != 4;
      v = 16'h40 + 16'($random(seed) & 63);
      wr(`CCU_IDX_VAL_LO, v[7:0]);
      wr(`CCU_IDX_VAL_HI, v[15:8]);
      wr(`CCU_IDX_FLAG, 8'h00);
      wr(`CCU_IDX_CTRL, {4'h0, modes[k]});
      run <= 1'b1;
      while (timer_count !== v) @(posedge mclk);
      #1;
      ck(cmp_out, k < 2);
      ck(timer_clear, k >= 3);
      ck(adc_start, k == 3);
      rd(`CCU_IDX_FLAG, 2'h0, 8'h04);
    end
    $display("test compare done");
    give_verdict();
  end
  // Watchdog far beyond the expected run length.
  initial
  begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule : tb
bind ccu_top ccu_checker u_ccu_checker (.*);
